// [pprt_pin_router.v]
// Function
// - Route registers enable, disable or move signal groups
// - Event A on PA2, or PA7 when set
// - Event B on PB2 only when clear
// - Event C on PC2, or PC7 when set
// - Event D on PD2, or PD7 when set
// - Event E on PE2 only when clear
// - Event F on PF2 only when clear
// - Table 4 out PB3 only when clear, inputs PB0-2
// - Table 3 on PF3/PF0-2 only when clear
// - Table 2 out PD3 or PD6, inputs PD0-2
// - Serial field: default, alternative, reserved, disconnected
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "pprt_defs.vh"
module pprt_pin_router #(
    parameter ADDR_W = 12
) (
    input wire REF_CLK,
    input wire RST,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [ADDR_W-1:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [3:0] PSTRB,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire [5:0] EVENT_SIG,
    input wire TABLE2_OUT,
    input wire TABLE3_OUT,
    input wire TABLE4_OUT,
    output reg [2:0] TABLE2_IN,
    output reg [2:0] TABLE3_IN,
    output reg [2:0] TABLE4_IN,
    input wire [2:0] PORTB_IN,
    input wire [2:0] PORTD_IN,
    input wire [2:0] PORTF_IN,
    output reg [7:0] PORTA_OUT,
    output reg [7:0] PORTA_OE,
    output reg [7:0] PORTB_OUT,
    output reg [7:0] PORTB_OE,
    output reg [7:0] PORTC_OUT,
    output reg [7:0] PORTC_OE,
    output reg [7:0] PORTD_OUT,
    output reg [7:0] PORTD_OE,
    output reg [7:0] PORTE_OUT,
    output reg [7:0] PORTE_OE,
    output reg [7:0] PORTF_OUT,
    output reg [7:0] PORTF_OE,
    output reg [4:0] SERIAL_DEFAULT_EN,
    output reg [4:0] SERIAL_ALT_EN
);
    reg [7:0] route_r [0:`PPRT_NUM_REGS-1];
    wire [3:0] idx = PADDR[5:2];
    wire mapped = (PADDR[ADDR_W-1:6] == {(ADDR_W-6){1'b0}}) && (idx <= `PPRT_IDX_LAST);
    wire access = PSEL & PENABLE;
    wire [7:0] rd_val = mapped ? route_r[idx] : 8'h00;
    wire [8:0] pins_sync;
    integer i;

    function [7:0] wr_mask;
        input [3:0] n;
        begin
            case (n)
                `PPRT_IDX_EVENT: wr_mask = `PPRT_MASK_EVENT;
                `PPRT_IDX_TABLE: wr_mask = `PPRT_MASK_TABLE;
                `PPRT_IDX_SERIAL_A: wr_mask = `PPRT_MASK_SERIAL_A;
                `PPRT_IDX_SERIAL_B: wr_mask = `PPRT_MASK_SERIAL_B;
                `PPRT_IDX_SPI: wr_mask = `PPRT_MASK_SPI;
                `PPRT_IDX_TWO_WIRE: wr_mask = `PPRT_MASK_TWO_WIRE;
                `PPRT_IDX_TIMER_A: wr_mask = `PPRT_MASK_TIMER_A;
                `PPRT_IDX_TIMER_B: wr_mask = `PPRT_MASK_TIMER_B;
                `PPRT_IDX_TIMER_D: wr_mask = `PPRT_MASK_TIMER_D;
                `PPRT_IDX_COMPARATOR: wr_mask = `PPRT_MASK_COMPARATOR;
                `PPRT_IDX_ZERO_CROSS: wr_mask = `PPRT_MASK_ZERO_CROSS;
                default: wr_mask = 8'h00;
            endcase
        end
    endfunction

    // Pin inputs come from outside the clock domain
    pprt_sync #(
        .W(9)
    ) u_sync (
        .clk(REF_CLK),
        .rst(RST),
        .d({PORTF_IN, PORTD_IN, PORTB_IN}),
        .q(pins_sync)
    );

    // One wait state keeps read data straight from a flop
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h00000000;
        end else if (access && !PREADY) begin
            PREADY <= 1'b1;
            PSLVERR <= ~mapped;
            PRDATA <= PWRITE ? 32'h00000000 : {24'h000000, rd_val};
        end else begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            for (i = 0; i < `PPRT_NUM_REGS; i = i + 1) begin
                route_r[i] <= `PPRT_RESET_ROUTE;
            end
        end else if (access && PREADY && PWRITE && mapped && PSTRB[0]) begin
            route_r[idx] <= PWDATA[7:0] & wr_mask(idx);
        end
    end

    wire [7:0] ev_route = route_r[`PPRT_IDX_EVENT];
    wire [7:0] tbl_route = route_r[`PPRT_IDX_TABLE];
    reg [7:0] pa_out_nxt;
    reg [7:0] pa_oe_nxt;
    reg [7:0] pb_out_nxt;
    reg [7:0] pb_oe_nxt;
    reg [7:0] pc_out_nxt;
    reg [7:0] pc_oe_nxt;
    reg [7:0] pd_out_nxt;
    reg [7:0] pd_oe_nxt;
    reg [7:0] pe_out_nxt;
    reg [7:0] pe_oe_nxt;
    reg [7:0] pf_out_nxt;
    reg [7:0] pf_oe_nxt;
    reg [2:0] t3_in_nxt;
    reg [4:0] ser_def_nxt;
    reg [4:0] ser_alt_nxt;
    reg [1:0] field;
    integer n;

    always @* begin
        pa_out_nxt = 8'h00;
        pa_oe_nxt = 8'h00;
        pb_out_nxt = 8'h00;
        pb_oe_nxt = 8'h00;
        pc_out_nxt = 8'h00;
        pc_oe_nxt = 8'h00;
        pd_out_nxt = 8'h00;
        pd_oe_nxt = 8'h00;
        pe_out_nxt = 8'h00;
        pe_oe_nxt = 8'h00;
        pf_out_nxt = 8'h00;
        pf_oe_nxt = 8'h00;
        t3_in_nxt = 3'h0;
        ser_def_nxt = 5'h00;
        ser_alt_nxt = 5'h00;
        field = 2'h0;
        if (!ev_route[`PPRT_BIT_EV_A]) begin
            pa_out_nxt[`PPRT_PIN_EV] = EVENT_SIG[`PPRT_BIT_EV_A];
            pa_oe_nxt[`PPRT_PIN_EV] = 1'b1;
        end else begin
            pa_out_nxt[`PPRT_PIN_EV_ALT] = EVENT_SIG[`PPRT_BIT_EV_A];
            pa_oe_nxt[`PPRT_PIN_EV_ALT] = 1'b1;
        end
        if (!ev_route[`PPRT_BIT_EV_B]) begin
            pb_out_nxt[`PPRT_PIN_EV] = EVENT_SIG[`PPRT_BIT_EV_B];
            pb_oe_nxt[`PPRT_PIN_EV] = 1'b1;
        end
        if (!ev_route[`PPRT_BIT_EV_C]) begin
            pc_out_nxt[`PPRT_PIN_EV] = EVENT_SIG[`PPRT_BIT_EV_C];
            pc_oe_nxt[`PPRT_PIN_EV] = 1'b1;
        end else begin
            pc_out_nxt[`PPRT_PIN_EV_ALT] = EVENT_SIG[`PPRT_BIT_EV_C];
            pc_oe_nxt[`PPRT_PIN_EV_ALT] = 1'b1;
        end
        if (!ev_route[`PPRT_BIT_EV_D]) begin
            pd_out_nxt[`PPRT_PIN_EV] = EVENT_SIG[`PPRT_BIT_EV_D];
            pd_oe_nxt[`PPRT_PIN_EV] = 1'b1;
        end else begin
            pd_out_nxt[`PPRT_PIN_EV_ALT] = EVENT_SIG[`PPRT_BIT_EV_D];
            pd_oe_nxt[`PPRT_PIN_EV_ALT] = 1'b1;
        end
        if (!ev_route[`PPRT_BIT_EV_E]) begin
            pe_out_nxt[`PPRT_PIN_EV] = EVENT_SIG[`PPRT_BIT_EV_E];
            pe_oe_nxt[`PPRT_PIN_EV] = 1'b1;
        end
        if (!ev_route[`PPRT_BIT_EV_F]) begin
            pf_out_nxt[`PPRT_PIN_EV] = EVENT_SIG[`PPRT_BIT_EV_F];
            pf_oe_nxt[`PPRT_PIN_EV] = 1'b1;
        end
        if (!tbl_route[`PPRT_BIT_TBL4]) begin
            pb_out_nxt[`PPRT_PIN_TBL_OUT] = TABLE4_OUT;
            pb_oe_nxt[`PPRT_PIN_TBL_OUT] = 1'b1;
        end
        if (!tbl_route[`PPRT_BIT_TBL3]) begin
            pf_out_nxt[`PPRT_PIN_TBL_OUT] = TABLE3_OUT;
            pf_oe_nxt[`PPRT_PIN_TBL_OUT] = 1'b1;
            t3_in_nxt = pins_sync[8:6];
        end
        if (!tbl_route[`PPRT_BIT_TBL2]) begin
            pd_out_nxt[`PPRT_PIN_TBL_OUT] = TABLE2_OUT;
            pd_oe_nxt[`PPRT_PIN_TBL_OUT] = 1'b1;
        end else begin
            pd_out_nxt[`PPRT_PIN_TBL_OUT_ALT] = TABLE2_OUT;
            pd_oe_nxt[`PPRT_PIN_TBL_OUT_ALT] = 1'b1;
        end
        // serial field decode, reserved connects nothing
        for (n = 0; n < `PPRT_SER_COUNT; n = n + 1) begin
            if (n < 4) begin
                field = route_r[`PPRT_IDX_SERIAL_A][2*n +: 2];
            end else begin
                field = route_r[`PPRT_IDX_SERIAL_B][1:0];
            end
            ser_def_nxt[n] = (field == `PPRT_SER_DEFAULT);
            ser_alt_nxt[n] = (field == `PPRT_SER_ALT);
        end
    end

    // Registered pins cost one cycle but keep glitches off the pads
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            PORTA_OUT <= 8'h00;
            PORTA_OE <= 8'h00;
            PORTB_OUT <= 8'h00;
            PORTB_OE <= 8'h00;
            PORTC_OUT <= 8'h00;
            PORTC_OE <= 8'h00;
            PORTD_OUT <= 8'h00;
            PORTD_OE <= 8'h00;
            PORTE_OUT <= 8'h00;
            PORTE_OE <= 8'h00;
            PORTF_OUT <= 8'h00;
            PORTF_OE <= 8'h00;
            TABLE2_IN <= 3'h0;
            TABLE3_IN <= 3'h0;
            TABLE4_IN <= 3'h0;
            SERIAL_DEFAULT_EN <= 5'h00;
            SERIAL_ALT_EN <= 5'h00;
        end else begin
            PORTA_OUT <= pa_out_nxt;
            PORTA_OE <= pa_oe_nxt;
            PORTB_OUT <= pb_out_nxt;
            PORTB_OE <= pb_oe_nxt;
            PORTC_OUT <= pc_out_nxt;
            PORTC_OE <= pc_oe_nxt;
            PORTD_OUT <= pd_out_nxt;
            PORTD_OE <= pd_oe_nxt;
            PORTE_OUT <= pe_out_nxt;
            PORTE_OE <= pe_oe_nxt;
            PORTF_OUT <= pf_out_nxt;
            PORTF_OE <= pf_oe_nxt;
            TABLE2_IN <= pins_sync[5:3];
            TABLE3_IN <= t3_in_nxt;
            TABLE4_IN <= pins_sync[2:0];
            SERIAL_DEFAULT_EN <= ser_def_nxt;
            SERIAL_ALT_EN <= ser_alt_nxt;
        end
    end
endmodule

// [pprt_defs.vh]
`ifndef PPRT_DEFS_VH
`define PPRT_DEFS_VH

// Register indices; byte address is four times the index
`define PPRT_IDX_EVENT 4'h0
`define PPRT_IDX_TABLE 4'h1
`define PPRT_IDX_SERIAL_A 4'h2
`define PPRT_IDX_SERIAL_B 4'h3
`define PPRT_IDX_SPI 4'h4
`define PPRT_IDX_TWO_WIRE 4'h5
`define PPRT_IDX_TIMER_A 4'h6
`define PPRT_IDX_TIMER_B 4'h7
`define PPRT_IDX_TIMER_D 4'h8
`define PPRT_IDX_COMPARATOR 4'h9
`define PPRT_IDX_ZERO_CROSS 4'hA
`define PPRT_IDX_LAST 4'hA
`define PPRT_NUM_REGS 11

// Writable bits of each register
`define PPRT_MASK_EVENT 8'h3F
`define PPRT_MASK_TABLE 8'h1F
`define PPRT_MASK_SERIAL_A 8'hFF
`define PPRT_MASK_SERIAL_B 8'h03
`define PPRT_MASK_SPI 8'h0F
`define PPRT_MASK_TWO_WIRE 8'h0F
`define PPRT_MASK_TIMER_A 8'h3F
`define PPRT_MASK_TIMER_B 8'h0F
`define PPRT_MASK_TIMER_D 8'h07
`define PPRT_MASK_COMPARATOR 8'h07
`define PPRT_MASK_ZERO_CROSS 8'h03

`define PPRT_RESET_ROUTE 8'h00

// Field positions in the event route register
`define PPRT_BIT_EV_A 0
`define PPRT_BIT_EV_B 1
`define PPRT_BIT_EV_C 2
`define PPRT_BIT_EV_D 3
`define PPRT_BIT_EV_E 4
`define PPRT_BIT_EV_F 5

// Field positions in the logic table route register
`define PPRT_BIT_TBL2 2
`define PPRT_BIT_TBL3 3
`define PPRT_BIT_TBL4 4

// Serial route field codes
`define PPRT_SER_DEFAULT 2'h0
`define PPRT_SER_ALT 2'h1
`define PPRT_SER_RSVD 2'h2
`define PPRT_SER_NONE 2'h3
`define PPRT_SER_COUNT 5

// Pin numbers inside a port
`define PPRT_PIN_EV 2
`define PPRT_PIN_EV_ALT 7
`define PPRT_PIN_TBL_OUT 3
`define PPRT_PIN_TBL_OUT_ALT 6

`endif

// [pprt_sync.v]
`timescale 1ns/1ps
module pprt_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire rst,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;
    wire [W-1:0] agree = ~(s2_r ^ s3_r);

    // Output moves only where the two later stages agree
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
            s3_r <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q <= (s2_r & agree) | (q & ~agree);
        end
    end
endmodule

// [pprt_pin_router_checker.sv]
`timescale 1ns/1ps
module pprt_checker (
    input wire REF_CLK,
    input wire RST,
    input wire PSEL,
    input wire PENABLE,
    input wire PREADY,
    input wire PSLVERR,
    input wire [5:0] EVENT_SIG,
    input wire [7:0] PORTA_OE,
    input wire [7:0] PORTA_OUT,
    input wire [7:0] PORTB_OE,
    input wire [7:0] PORTC_OE,
    input wire [7:0] PORTD_OE,
    input wire [4:0] SERIAL_DEFAULT_EN,
    input wire [4:0] SERIAL_ALT_EN
);
    // Pins hold zeros until the first edge after reset, so checks start one edge later
    reg up_r;
    always @(posedge REF_CLK or posedge RST) begin
        if (RST)
            up_r <= 1'b0;
        else
            up_r <= 1'b1;
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    rst_dflt_a: assert property (up_r && !$past(up_r) |-> PORTA_OE == 8'h04 && PORTB_OE == 8'h0C)
        else $error("pins not at default after reset");
    ev_a_one_a: assert property (up_r |-> $onehot({PORTA_OE[7], PORTA_OE[2]}))
        else $error("event A not on exactly one pin");
    ev_a_data_a: assert property (up_r && PORTA_OE[2] |-> PORTA_OUT[2] == $past(EVENT_SIG[0]))
        else $error("event A value not passed to pin");
    ev_c_one_a: assert property (up_r |-> $onehot({PORTC_OE[7], PORTC_OE[2]}))
        else $error("event C not on exactly one pin");
    ev_d_one_a: assert property (up_r |-> $onehot({PORTD_OE[7], PORTD_OE[2]}))
        else $error("event D not on exactly one pin");
    tbl2_one_a: assert property (up_r |-> $onehot({PORTD_OE[6], PORTD_OE[3]}))
        else $error("table 2 output not on exactly one pin");
    ser_excl_a: assert property (up_r |-> (SERIAL_DEFAULT_EN & SERIAL_ALT_EN) == 5'h00)
        else $error("serial on both pin sets");
    bus_wait_a: assert property (PSEL && PENABLE && !$past(PENABLE) |-> !PREADY ##1 PREADY)
        else $error("access phase not two cycles");
    err_pulse_a: assert property (PSLVERR |-> PREADY ##1 !PSLVERR)
        else $error("error flag not a single answer pulse");
    cover property (PSLVERR);
    cover property (PORTA_OE[7]);
    cover property (SERIAL_ALT_EN == 5'h1F);
endmodule

bind pprt_pin_router pprt_checker i_chk (.REF_CLK, .RST, .PSEL, .PENABLE, .PREADY, .PSLVERR, .EVENT_SIG,
    .PORTA_OE, .PORTA_OUT, .PORTB_OE, .PORTC_OE, .PORTD_OE, .SERIAL_DEFAULT_EN, .SERIAL_ALT_EN);

// [pprt_pins.sv]
`timescale 1ns/1ps
module pprt_pins (
    input wire [8:0] lvl,
    input wire [2:0] b_out,
    input wire [2:0] b_oe,
    input wire [2:0] d_out,
    input wire [2:0] d_oe,
    input wire [2:0] f_out,
    input wire [2:0] f_oe,
    output wire [2:0] b_in,
    output wire [2:0] d_in,
    output wire [2:0] f_in
);
    // A driven pin reads back the router's value, an idle one the outside level
    assign b_in = (b_oe & b_out) | (~b_oe & lvl[2:0]);
    assign d_in = (d_oe & d_out) | (~d_oe & lvl[5:3]);
    assign f_in = (f_oe & f_out) | (~f_oe & lvl[8:6]);
endmodule

// [test_pprt_pin_router.sv]
`timescale 1ns/1ps
module test_pprt_pin_router;
    logic REF_CLK = 1'b0;
    logic RST = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0;
    logic [3:0] PSTRB = 4'hF;
    logic [5:0] EVENT_SIG = 6'h00;
    logic TABLE2_OUT = 1'b0;
    logic TABLE3_OUT = 1'b0;
    logic TABLE4_OUT = 1'b0;
    logic [8:0] lvl = 9'h000;
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR;
    wire [2:0] TABLE2_IN, TABLE3_IN, TABLE4_IN, PORTB_IN, PORTD_IN, PORTF_IN;
    wire [7:0] PORTA_OUT, PORTA_OE, PORTB_OUT, PORTB_OE, PORTC_OUT, PORTC_OE;
    wire [7:0] PORTD_OUT, PORTD_OE, PORTE_OUT, PORTE_OE, PORTF_OUT, PORTF_OE;
    wire [4:0] SERIAL_DEFAULT_EN, SERIAL_ALT_EN;
    wire [47:0] oe = {PORTF_OE, PORTE_OE, PORTD_OE, PORTC_OE, PORTB_OE, PORTA_OE};
    wire [47:0] po = {PORTF_OUT, PORTE_OUT, PORTD_OUT, PORTC_OUT, PORTB_OUT, PORTA_OUT};
    logic [31:0] rq;
    logic re;
    int mismatches = 0;
    int samples_checked = 0;
    logic [7:0] msk [0:11] = '{8'h3F, 8'h1F, 8'hFF, 8'h03, 8'h0F, 8'h0F, 8'h3F, 8'h0F, 8'h07, 8'h07, 8'h03, 8'h00};
    localparam logic [47:0] DFLT = 48'h0C040C040C04;

    pprt_pin_router i_dut (.REF_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA, .PREADY,
        .PSLVERR, .EVENT_SIG, .TABLE2_OUT, .TABLE3_OUT, .TABLE4_OUT, .TABLE2_IN, .TABLE3_IN, .TABLE4_IN,
        .PORTB_IN, .PORTD_IN, .PORTF_IN, .PORTA_OUT, .PORTA_OE, .PORTB_OUT, .PORTB_OE, .PORTC_OUT, .PORTC_OE,
        .PORTD_OUT, .PORTD_OE, .PORTE_OUT, .PORTE_OE, .PORTF_OUT, .PORTF_OE, .SERIAL_DEFAULT_EN, .SERIAL_ALT_EN);
    pprt_pins i_pins (.lvl(lvl), .b_out(PORTB_OUT[2:0]), .b_oe(PORTB_OE[2:0]), .d_out(PORTD_OUT[2:0]),
        .d_oe(PORTD_OE[2:0]), .f_out(PORTF_OUT[2:0]), .f_oe(PORTF_OE[2:0]), .b_in(PORTB_IN), .d_in(PORTD_IN),
        .f_in(PORTF_IN));

    always #2 REF_CLK = ~REF_CLK;

    task chk(input logic [47:0] g, input logic [47:0] x);
        begin
            samples_checked++;
            if (g !== x) begin
                mismatches++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
            end
        end
    endtask

    // Holds the request until pready is seen high, then releases
    task apb(input logic w, input logic [3:0] i, input logic [31:0] d, output logic [31:0] q, output logic e);
        begin
            @(posedge REF_CLK);
            PSEL <= 1'b1;
            PWRITE <= w;
            PADDR <= {6'h00, i, 2'h0};
            PWDATA <= d;
            @(posedge REF_CLK);
            PENABLE <= 1'b1;
            // No cycle count assumed; only the watchdog ends a stuck wait
            do begin
                @(posedge REF_CLK);
            end while (PREADY !== 1'b1);
            q = PRDATA;
            e = PSLVERR;
            PSEL <= 1'b0;
            PENABLE <= 1'b0;
        end
    endtask

    task settle;
        begin
            repeat (2) @(posedge REF_CLK);
            #1;
        end
    endtask

    task t_reset;
        int i;
        begin
            for (i = 0; i < 11; i++) begin
                apb(1'b0, i[3:0], 32'h0, rq, re);
                chk(48'({re, rq}), 48'h0);
            end
            #1;
            chk(oe, DFLT);
            chk(48'({SERIAL_ALT_EN, SERIAL_DEFAULT_EN}), 48'h1F);
        end
    endtask

    task t_event;
        int b;
        int v;
        logic [47:0] e;
        logic [47:0] a;
        begin
            @(posedge REF_CLK);
            TABLE2_OUT <= 1'b1;
            TABLE3_OUT <= 1'b1;
            TABLE4_OUT <= 1'b1;
            for (b = 0; b < 6; b++) begin
                // One event high at a time so a swapped route shows up
                @(posedge REF_CLK);
                EVENT_SIG <= 6'(1 << b);
                e = 48'h04 << (8 * b);
                a = (b == 1 || b >= 4) ? 48'h0 : 48'h80 << (8 * b);
                for (v = 0; v < 2; v++) begin
                    apb(1'b1, 4'h0, 32'(v << b), rq, re);
                    settle;
                    chk(oe, v ? (DFLT & ~e) | a : DFLT);
                    chk(po, 48'h080008000800 | (v ? a : e));
                end
            end
            @(posedge REF_CLK);
            EVENT_SIG <= 6'h00;
            TABLE2_OUT <= 1'b0;
            TABLE3_OUT <= 1'b0;
            TABLE4_OUT <= 1'b0;
            settle;
            chk(po, 48'h0);
        end
    endtask

    task t_table;
        begin
            apb(1'b1, 4'h0, 32'h2A, rq, re);
            apb(1'b1, 4'h1, 32'h1C, rq, re);
            @(posedge REF_CLK);
            lvl <= 9'h1B5;
            repeat (7) @(posedge REF_CLK);
            #1;
            chk(oe, 48'h0004C0040004);
            chk(48'({TABLE4_IN, TABLE3_IN, TABLE2_IN}), 48'h146);
            apb(1'b1, 4'h1, 32'h0, rq, re);
            repeat (7) @(posedge REF_CLK);
            #1;
            chk(oe, 48'h080488040804);
            chk(48'({TABLE4_IN, TABLE3_IN, TABLE2_IN}), 48'h176);
        end
    endtask

    task t_serial;
        int v;
        begin
            for (v = 0; v < 4; v++) begin
                apb(1'b1, 4'h2, {24'h0, {4{v[1:0]}}}, rq, re);
                apb(1'b1, 4'h3, 32'(v), rq, re);
                settle;
                chk(48'({SERIAL_ALT_EN, SERIAL_DEFAULT_EN}), 48'(v == 1 ? 10'h3E0 : v == 0 ? 10'h1F : 10'h0));
            end
        end
    endtask

    // Index 11 is unmapped and must answer with an error and zero
    task t_regs;
        int i;
        begin
            for (i = 0; i < 12; i++) begin
                apb(1'b1, i[3:0], 32'hFFFFFFFF, rq, re);
                apb(1'b0, i[3:0], 32'h0, rq, re);
                chk(48'({re, rq}), 48'({i == 11, 24'h0, msk[i]}));
            end
            // Byte lane 0 off: the write must be dropped
            PSTRB <= 4'hE;
            apb(1'b1, 4'h4, 32'h0, rq, re);
            PSTRB <= 4'hF;
            apb(1'b0, 4'h4, 32'h0, rq, re);
            chk(48'({re, rq}), 48'h0F);
        end
    endtask

    task results;
        begin
            $display("checks %0d mismatches %0d", samples_checked, mismatches);
            if (mismatches == 0 && samples_checked > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    initial begin
        repeat (8) @(posedge REF_CLK);
        RST <= 1'b0;
        t_reset;
        $display("reset test done");
        t_event;
        $display("event test done");
        t_table;
        $display("table test done");
        t_serial;
        $display("serial test done");
        t_regs;
        $display("register test done");
        results;
    end

    initial begin
        #40000;
        mismatches++;
        results;
    end
endmodule
